// ==== bench/iem_src.sv ====
`timescale 1ns/1ps
// request sources hold level flags until the bench drops them
module iem_src (
  input wire logic [7:0] req,
  output logic [7:0] flags
);
  assign flags = req;
endmodule

// ==== bench/test_interrupt_enable_mask.sv ====
`timescale 1ns/1ps
module test_interrupt_enable_mask;
  import iem_pkg::*;
  logic mclk = 1'h0, rstn = 1'h0, sfrWrite = 1'h0, sfrBitWrite = 1'h0, sfrBitVal = 1'h0, irqPending;
  logic [7:0] sfrAddr = IEM_REG_ADDR, sfrWdata = 8'h00, sfrRdata, req = 8'h00, flags;
  logic [2:0] sfrBitSel = 3'h0;
  logic [6:0] maskedIrq;
  int numErrors = 0, nChecks = 0;
  iem_src iem_src_i (.req(req), .flags(flags));
  iem_interrupt_enable_mask iem_interrupt_enable_mask_i (.mclk(mclk), .rstn(rstn), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrBitWrite(sfrBitWrite), .sfrBitSel(sfrBitSel),
    .sfrBitVal(sfrBitVal), .sfrRdata(sfrRdata), .ext_irq_input_zero(flags[0]),
    .timer_zero_overflow_flag(flags[1]), .ext_irq_input_one(flags[2]), .timer_one_overflow_flag(flags[3]),
    .uartIrqFlag(flags[4]), .timer_two_low_overflow_flag(flags[5]), .timer_two_high_overflow_flag(flags[7]),
    .spiIrqFlag(flags[6]), .maskedIrq(maskedIrq), .irqPending(irqPending));
  initial forever #10 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobes, then one more edge for the masked outputs to follow
  task automatic wr(input logic [7:0] d);
    sfrWrite = 1'h1;
    sfrWdata = d;
    tick(1);
    sfrWrite = 1'h0;
    tick(1);
  endtask
  task automatic bw(input logic [2:0] sel, input logic val);
    sfrBitWrite = 1'h1;
    sfrBitSel = sel;
    sfrBitVal = val;
    tick(1);
    sfrBitWrite = 1'h0;
    tick(1);
  endtask
  task automatic finalReport;
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // tests need under forty cycles, so fifty times that means a hang
  initial begin
    repeat (2000) @(posedge mclk);
    numErrors++;
    finalReport;
  end
  initial begin
    tick(2);
    rstn = 1'h1;
    tick(1);
    chk(sfrRdata, IEM_RESET_VAL, "reset value");
    $display("reset value test done");
    req = 8'hFF;
    for (int i = 0; i < IEM_NUM_SRC; i++) begin
      wr(8'h80 | (8'h01 << i));
      chk({irqPending, maskedIrq}, 8'h80 | (8'h01 << i), "single source");
    end
    $display("single source test done");
    wr(8'h7F);
    chk({irqPending, maskedIrq}, 8'h00, "global gate off");
    chk(sfrRdata, 8'h7F, "readback");
    $display("global gate test done");
    req = 8'h80;
    wr(8'hA0);
    chk({irqPending, maskedIrq}, 8'hA0, "timer two high");
    req = 8'h20;
    tick(1);
    chk({irqPending, maskedIrq}, 8'hA0, "timer two low");
    bw(3'h5, 1'h0);
    chk({irqPending, maskedIrq}, 8'h00, "timer two masked");
    bw(3'h5, 1'h1);
    chk({irqPending, maskedIrq}, 8'hA0, "timer two bit set");
    $display("timer two test done");
    req = 8'h00;
    tick(1);
    chk({irqPending, maskedIrq}, 8'h00, "request dropped");
    req = 8'h20;
    tick(1);
    chk({irqPending, maskedIrq}, 8'hA0, "request after one cycle");
    $display("latency test done");
    sfrAddr = 8'h10;
    wr(8'hFF);
    chk(sfrRdata, 8'h00, "unmapped read");
    sfrAddr = IEM_REG_ADDR;
    tick(1);
    chk(sfrRdata, 8'hA0, "unmapped write ignored");
    // byte and bit strobe in one cycle: the byte must win
    sfrWrite = 1'h1;
    sfrWdata = 8'h84;
    sfrBitWrite = 1'h1;
    sfrBitSel = 3'h5;
    sfrBitVal = 1'h1;
    tick(1);
    sfrWrite = 1'h0;
    sfrBitWrite = 1'h0;
    tick(1);
    chk(sfrRdata, 8'h84, "byte beats bit");
    chk({irqPending, maskedIrq}, 8'h00, "bit write refused");
    req = 8'h04;
    sfrAddr = 8'h10;
    bw(3'h5, 1'h1);
    sfrAddr = IEM_REG_ADDR;
    tick(1);
    chk(sfrRdata, 8'h84, "unmapped bit write ignored");
    chk({irqPending, maskedIrq}, 8'h84, "external one passed");
    $display("register access test done");
    rstn = 1'h0;
    tick(1);
    rstn = 1'h1;
    tick(1);
    chk(sfrRdata, IEM_RESET_VAL, "register after second reset");
    chk({irqPending, maskedIrq}, 8'h00, "outputs after second reset");
    $display("second reset test done");
    finalReport;
  end
endmodule

// ==== rtl/iem_interrupt_enable_mask.sv ====
`timescale 1ns/1ps
// Summary of operation
// - global gate clear blocks all sources
// - global gate set passes only sources whose mask bit is set
// - bit five gates both timer two flags
// - bit four gates the uart request
// - bit three gates timer one overflow
// - bit two gates external input one
// - masked requests sampled every clock cycle
module iem_interrupt_enable_mask
  import iem_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrBitWrite,
  input wire logic [2:0] sfrBitSel,
  input wire logic sfrBitVal,
  output logic [7:0] sfrRdata,
  input wire logic ext_irq_input_zero,
  input wire logic timer_zero_overflow_flag,
  input wire logic ext_irq_input_one,
  input wire logic timer_one_overflow_flag,
  input wire logic uartIrqFlag,
  input wire logic timer_two_low_overflow_flag,
  input wire logic timer_two_high_overflow_flag,
  input wire logic spiIrqFlag,
  output logic [6:0] maskedIrq,
  output logic irqPending
);
  logic [7:0] interrupt_enable_mask_reg;
  logic [7:0] next_interrupt_enable_mask_reg;
  logic [6:0] next_maskedIrq;
  logic next_irqPending;
  logic [7:0] next_sfrRdata;
  logic [6:0] rawIrq;
  logic global_irq_gate;

  assign global_irq_gate = interrupt_enable_mask_reg[IEM_POS_GLOBAL];

  // raw requests ordered by mask bit position
  always_comb begin
    rawIrq[IEM_POS_EXT0] = ext_irq_input_zero;
    rawIrq[IEM_POS_T0] = timer_zero_overflow_flag;
    rawIrq[IEM_POS_EXT1] = ext_irq_input_one;
    rawIrq[IEM_POS_T1] = timer_one_overflow_flag;
    rawIrq[IEM_POS_UART] = uartIrqFlag;
    rawIrq[IEM_POS_T2] = timer_two_low_overflow_flag | timer_two_high_overflow_flag;
    rawIrq[IEM_POS_SPI] = spiIrqFlag;
  end

  // one decode for the write, bit write and read paths
  function automatic logic addrHit(input logic [7:0] addr);
    return addr == IEM_REG_ADDR;
  endfunction

  // byte write wins over a bit write in the same cycle, so no merged value is stored
  always_comb begin
    next_interrupt_enable_mask_reg = interrupt_enable_mask_reg;
    if (sfrWrite && addrHit(sfrAddr)) begin
      next_interrupt_enable_mask_reg = sfrWdata;
    end else if (sfrBitWrite && addrHit(sfrAddr)) begin
      next_interrupt_enable_mask_reg[sfrBitSel] = sfrBitVal;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_mask_reg <= IEM_RESET_VAL;
    end else begin
      interrupt_enable_mask_reg <= next_interrupt_enable_mask_reg;
    end
  end

  // other addresses read as zero, so several registers can share the read bus by an or
  always_comb begin
    next_sfrRdata = 8'h00;
    if (addrHit(sfrAddr)) begin
      next_sfrRdata = interrupt_enable_mask_reg;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= next_sfrRdata;
    end
  end

  // flags come from logic on this clock, so no synchroniser; the flop costs one cycle
  always_comb begin
    next_maskedIrq = rawIrq & interrupt_enable_mask_reg[6:0];
    if (!global_irq_gate) begin
      next_maskedIrq = 7'h00;
    end
    next_irqPending = |next_maskedIrq;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      maskedIrq <= 7'h00;
      irqPending <= 1'h0;
    end else begin
      maskedIrq <= next_maskedIrq;
      irqPending <= next_irqPending;
    end
  end

  // global gate, and all source masks clear
  a_global_blocks_all: assert property (@(posedge mclk) disable iff (!rstn)
    !global_irq_gate |=> maskedIrq == 7'h00)
    else $error("request passed with global gate clear");

  a_pending_gated: assert property (@(posedge mclk) disable iff (!rstn)
    !global_irq_gate |=> !irqPending)
    else $error("pending raised with global gate clear");

  a_gate_open_pass: assert property (@(posedge mclk) disable iff (!rstn)
    global_irq_gate |=> maskedIrq == $past(rawIrq & interrupt_enable_mask_reg[6:0]))
    else $error("enabled request not passed");

  a_masks_all_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (interrupt_enable_mask_reg[6:0] == 7'h00) |=> maskedIrq == 7'h00)
    else $error("request passed with every source masked");

  // timer two, either flag
  a_timer_two_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_T2] && timer_two_high_overflow_flag)
    |=> maskedIrq[IEM_POS_T2])
    else $error("timer two high flag lost");

  a_timer_two_low: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_T2] && timer_two_low_overflow_flag)
    |=> maskedIrq[IEM_POS_T2])
    else $error("timer two low flag lost");

  a_timer_two_off: assert property (@(posedge mclk) disable iff (!rstn)
    !interrupt_enable_mask_reg[IEM_POS_T2] |=> !maskedIrq[IEM_POS_T2])
    else $error("timer two passed while masked");

  // uart
  a_uart_gate: assert property (@(posedge mclk) disable iff (!rstn)
    !interrupt_enable_mask_reg[IEM_POS_UART] |=> !maskedIrq[IEM_POS_UART])
    else $error("uart passed while masked");

  a_uart_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_UART] && uartIrqFlag)
    |=> maskedIrq[IEM_POS_UART])
    else $error("uart request lost");

  // timer one
  a_timer_one_gate: assert property (@(posedge mclk) disable iff (!rstn)
    !interrupt_enable_mask_reg[IEM_POS_T1] |=> !maskedIrq[IEM_POS_T1])
    else $error("timer one passed while masked");

  a_timer_one_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_T1] && timer_one_overflow_flag)
    |=> maskedIrq[IEM_POS_T1])
    else $error("timer one request lost");

  // external input one
  a_ext_one_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_EXT1] && ext_irq_input_one)
    |=> maskedIrq[IEM_POS_EXT1])
    else $error("external one lost");

  a_ext_one_off: assert property (@(posedge mclk) disable iff (!rstn)
    !interrupt_enable_mask_reg[IEM_POS_EXT1] |=> !maskedIrq[IEM_POS_EXT1])
    else $error("external one passed while masked");

  // spi, timer zero, external input zero
  a_low_bits_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (!interrupt_enable_mask_reg[IEM_POS_SPI] && !interrupt_enable_mask_reg[IEM_POS_T0])
    |=> !maskedIrq[IEM_POS_SPI] && !maskedIrq[IEM_POS_T0])
    else $error("spi or t0 passed");

  a_ext_zero_off: assert property (@(posedge mclk) disable iff (!rstn)
    !interrupt_enable_mask_reg[IEM_POS_EXT0] |=> !maskedIrq[IEM_POS_EXT0])
    else $error("external zero passed while masked");

  a_spi_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_SPI] && spiIrqFlag)
    |=> maskedIrq[IEM_POS_SPI])
    else $error("spi request lost");

  a_timer_zero_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_T0] && timer_zero_overflow_flag)
    |=> maskedIrq[IEM_POS_T0])
    else $error("timer zero request lost");

  a_ext_zero_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && interrupt_enable_mask_reg[IEM_POS_EXT0] && ext_irq_input_zero)
    |=> maskedIrq[IEM_POS_EXT0])
    else $error("external zero lost");

  // one cycle from pending request to output
  a_pending_follows: assert property (@(posedge mclk) disable iff (!rstn)
    irqPending == ($past(global_irq_gate) && ($past(rawIrq & interrupt_enable_mask_reg[6:0]) != 7'h00)))
    else $error("pending disagrees with requests");

  a_pending_rises: assert property (@(posedge mclk) disable iff (!rstn)
    (global_irq_gate && ((rawIrq & interrupt_enable_mask_reg[6:0]) != 7'h00)) |=> irqPending)
    else $error("enabled request not pending after one cycle");

  a_idle_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    (rawIrq == 7'h00) |=> (maskedIrq == 7'h00) && !irqPending)
    else $error("request shown with no source raised");

  // register access
  a_write_takes: assert property (@(posedge mclk) disable iff (!rstn)
    (sfrWrite && addrHit(sfrAddr)) |=> interrupt_enable_mask_reg == $past(sfrWdata))
    else $error("register write lost");

  a_bit_write_lands: assert property (@(posedge mclk) disable iff (!rstn)
    (sfrBitWrite && !sfrWrite && addrHit(sfrAddr))
    |=> interrupt_enable_mask_reg[$past(sfrBitSel)] == $past(sfrBitVal))
    else $error("bit write lost");

  a_bit_write_keeps: assert property (@(posedge mclk) disable iff (!rstn)
    (sfrBitWrite && !sfrWrite && addrHit(sfrAddr))
    |=> (interrupt_enable_mask_reg & ~(8'h01 << $past(sfrBitSel)))
      == ($past(interrupt_enable_mask_reg) & ~(8'h01 << $past(sfrBitSel))))
    else $error("bit write touched other bits");

  a_foreign_write: assert property (@(posedge mclk) disable iff (!rstn)
    !addrHit(sfrAddr) |=> $stable(interrupt_enable_mask_reg))
    else $error("register changed by another address");

  a_read_mapped: assert property (@(posedge mclk) disable iff (!rstn)
    addrHit(sfrAddr) |=> sfrRdata == $past(interrupt_enable_mask_reg))
    else $error("read data differs from register");

  a_read_unmapped: assert property (@(posedge mclk) disable iff (!rstn)
    !addrHit(sfrAddr) |=> sfrRdata == 8'h00)
    else $error("other address read not zero");

  c_global_on: cover property (@(posedge mclk) disable iff (!rstn) $rose(global_irq_gate));
  c_pending: cover property (@(posedge mclk) disable iff (!rstn) irqPending);
  c_t2_low: cover property (@(posedge mclk) disable iff (!rstn)
    maskedIrq[IEM_POS_T2] && timer_two_low_overflow_flag);
  c_bit_write: cover property (@(posedge mclk) disable iff (!rstn) sfrBitWrite && addrHit(sfrAddr));
  c_byte_beats_bit: cover property (@(posedge mclk) disable iff (!rstn)
    sfrWrite && sfrBitWrite && addrHit(sfrAddr));
endmodule

// ==== rtl/iem_pkg.sv ====
package iem_pkg;
  localparam logic [7:0] IEM_REG_ADDR = 8'hA8;
  localparam logic [7:0] IEM_RESET_VAL = 8'h00;
  localparam int IEM_POS_GLOBAL = 7;
  localparam int IEM_POS_SPI = 6;
  localparam int IEM_POS_T2 = 5;
  localparam int IEM_POS_UART = 4;
  localparam int IEM_POS_T1 = 3;
  localparam int IEM_POS_EXT1 = 2;
  localparam int IEM_POS_T0 = 1;
  localparam int IEM_POS_EXT0 = 0;
  localparam int IEM_NUM_SRC = 7;
endpackage
